// [bench/host_cpu.sv]
module host_cpu (
   // Clock.
   input  wire logic       core_clk,
   // Data bus.
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n,
   output logic      [7:0] data_in,
   // Select and strobes.
   output logic            port_select_lo,
   output logic            port_select_hi,
   output logic            chip_sel_n,
   output logic            read_n,
   output logic            write_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       drv_en;
   logic [7:0] drv_val;
   logic [7:0] last_q;

   // A floating bus shows the inverse of its last level, so stale data never passes as a match.
   assign data_in = !data_oe_n ? data_out : (drv_en ? drv_val : ~last_q);
   always @(posedge core_clk) last_q <= data_in;

   initial begin
      drv_en = 1'b0;
      drv_val = 8'h00;
      last_q = 8'h00;
      {port_select_hi, port_select_lo} = 2'h0;
      chip_sel_n = 1'b1;
      read_n = 1'b1;
      write_n = 1'b1;
   end

   // Strobes stand six cycles and rest six, three times what the two-stage synchronisers need.
   task automatic access(input logic wr, input logic [1:0] port, input logic [7:0] wdata, input logic sel,
                         output logic [7:0] rdata, output logic drove);
      drove = 1'b0;
      @(posedge core_clk);
      #2;
      {port_select_hi, port_select_lo} = port;
      drv_en = wr;
      drv_val = wdata;
      chip_sel_n = ~sel;
      write_n = ~wr;
      read_n = wr;
      repeat (6) begin
         @(posedge core_clk);
         if (data_oe_n === 1'b0) drove = 1'b1;
      end
      rdata = data_in;
      #2;
      chip_sel_n = 1'b1;
      write_n = 1'b1;
      read_n = 1'b1;
      drv_en = 1'b0;
      repeat (6) @(posedge core_clk);
   endtask

   // Control word first, then the count bytes in the chosen format.
   task automatic load_counter(input logic [1:0] c, input logic [1:0] acc, input logic [2:0] mode,
                               input logic [15:0] n);
      logic [7:0] d;
      logic       f;
      access(1'b1, timer_pkg::PORT_CTRL, {c, acc, mode, 1'b0}, 1'b1, d, f);
      if (acc != timer_pkg::ACC_HI_ONLY) access(1'b1, c, n[7:0], 1'b1, d, f);
      if (acc != timer_pkg::ACC_LO_ONLY) access(1'b1, c, n[15:8], 1'b1, d, f);
   endtask
endmodule

// [bench/interval_timer_bus_programming_tb.sv]
module interval_timer_bus_programming_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk;
   logic        rst_n;
   logic        ce;
   logic [7:0]  data_in;
   logic [7:0]  data_out;
   logic        data_oe_n;
   logic        port_select_lo;
   logic        port_select_hi;
   logic        chip_sel_n;
   logic        read_n;
   logic        write_n;
   logic [2:0]  count_clk;
   logic [2:0]  count_gate;
   logic [2:0]  count_out;
   int          errors;
   int          tests_run;
   logic [15:0] v [3];
   logic [15:0] w;
   logic [15:0] n;
   logic [7:0]  d;
   logic [7:0]  b;
   logic        f;
   logic [1:0]  c;
   logic [7:0]  seq [9] = '{8'h31, 8'h30, 8'h01, 8'h32, 8'h00, 8'h11, 8'h02, 8'h10, 8'h12};

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   interval_timer dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .port_select_lo(port_select_lo), .port_select_hi(port_select_hi),
      .chip_sel_n(chip_sel_n), .read_n(read_n), .write_n(write_n), .count_clk(count_clk),
      .count_gate(count_gate), .count_out(count_out)
   );
   host_cpu host_u (
      .core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
      .port_select_lo(port_select_lo), .port_select_hi(port_select_hi), .chip_sel_n(chip_sel_n),
      .read_n(read_n), .write_n(write_n)
   );

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [1:0] port, input logic [7:0] data);
      logic [7:0] x;
      logic       y;
      host_u.access(1'b1, port, data, 1'b1, x, y);
   endtask

   task automatic rd16(input logic [1:0] cn, output logic [15:0] val);
      logic [7:0] lo;
      logic [7:0] hi;
      logic       y;
      host_u.access(1'b0, cn, 8'h00, 1'b1, lo, y);
      host_u.access(1'b0, cn, 8'h00, 1'b1, hi, y);
      val = {hi, lo};
   endtask

   // One falling edge on each counter clock picked by the mask.
   task automatic tick(input logic [2:0] m);
      @(posedge core_clk);
      #2;
      count_clk = ~m;
      repeat (4) @(posedge core_clk);
      #2;
      count_clk = 3'h7;
      repeat (4) @(posedge core_clk);
      #2;
   endtask

   function automatic logic [7:0] cw(input logic [1:0] cn, input logic [1:0] acc, input logic [2:0] mode);
      return {cn, acc, mode, 1'b0};
   endfunction

   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   initial begin
      ce = 1'b1;
      rst_n = 1'b0;
      count_clk = 3'h7;
      count_gate = 3'h0;
      errors = 0;
      tests_run = 0;
      void'($urandom(32'hd0de_10fb));
      repeat (8) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #2;
      check("oe_after_reset", data_oe_n, 1'b1);
      check("out_after_reset", count_out, 3'h0);
      $display("test reset done");
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 3; i++) v[i] = 16'($urandom_range(16'hffff, 16'h0100));
         for (int i = 0; i < 9; i++) begin
            c = seq[i][1:0];
            if (seq[i][5:4] == 2'h3) wr(timer_pkg::PORT_CTRL, cw(c, timer_pkg::ACC_BOTH, 3'($urandom_range(5))));
            else wr(c, seq[i][4] ? v[c][15:8] : v[c][7:0]);
         end
         tick(3'h7);
         for (int i = 0; i < 3; i++) begin
            rd16(2'(i), w);
            check("count_read", w, v[i]);
         end
      end
      $display("test interleave done");
      n = 16'($urandom_range(16'hffff, 16'h0100));
      wr(2'h0, n[7:0]);
      tick(3'h1);
      rd16(2'h0, w);
      check("half_written", w, v[0]);
      wr(2'h0, n[15:8]);
      tick(3'h1);
      rd16(2'h0, w);
      check("full_written", w, n);
      $display("test holding done");
      b = 8'($urandom_range(200, 2));
      host_u.load_counter(2'h1, timer_pkg::ACC_HI_ONLY, timer_pkg::MODE_TERM_IRQ, {b, 8'h00});
      tick(3'h2);
      count_gate = 3'h2;
      tick(3'h2);
      count_gate = 3'h0;
      host_u.access(1'b0, 2'h1, 8'h00, 1'b1, d, f);
      check("high_only", d, b - 8'h01);
      host_u.load_counter(2'h1, timer_pkg::ACC_LO_ONLY, timer_pkg::MODE_TERM_IRQ, 16'h0005);
      tick(3'h2);
      check("out_programmed", count_out[1], 1'b0);
      count_gate = 3'h2;
      repeat (3) tick(3'h2);
      check("out_counting", count_out[1], 1'b0);
      repeat (3) tick(3'h2);
      check("out_terminal", count_out[1], 1'b1);
      count_gate = 3'h0;
      $display("test one byte done");
      n = 16'($urandom_range(16'hffff, 16'h1000));
      host_u.load_counter(2'h2, timer_pkg::ACC_BOTH, timer_pkg::MODE_TERM_IRQ, n);
      tick(3'h4);
      count_gate = 3'h4;
      repeat (2) tick(3'h4);
      wr(timer_pkg::PORT_CTRL, cw(2'h2, timer_pkg::ACC_LATCH, 3'h0));
      tick(3'h4);
      wr(timer_pkg::PORT_CTRL, cw(2'h2, timer_pkg::ACC_LATCH, 3'h0));
      tick(3'h4);
      count_gate = 3'h0;
      rd16(2'h2, w);
      check("latched", w, n - 16'h0002);
      rd16(2'h2, w);
      check("tracking", w, n - 16'h0004);
      $display("test latch done");
      // Read-back of status only, counter 2.
      wr(timer_pkg::PORT_CTRL, 8'he8);
      host_u.access(1'b0, 2'h2, 8'h00, 1'b1, d, f);
      check("status", d, {2'b00, timer_pkg::ACC_BOTH, timer_pkg::MODE_TERM_IRQ, 1'b0});
      rd16(2'h2, w);
      check("after_status", w, n - 16'h0004);
      host_u.access(1'b0, timer_pkg::PORT_CTRL, 8'h00, 1'b1, d, f);
      check("ctrl_read_drove", f, 1'b0);
      $display("test status done");
      host_u.access(1'b1, timer_pkg::PORT_CTRL, cw(2'h2, timer_pkg::ACC_LO_ONLY, 3'h0), 1'b0, d, f);
      host_u.access(1'b1, 2'h2, 8'h5a, 1'b0, d, f);
      host_u.access(1'b0, 2'h2, 8'h00, 1'b0, d, f);
      check("unselected_read", f, 1'b0);
      tick(3'h4);
      rd16(2'h2, w);
      check("unselected_write", w, n - 16'h0004);
      $display("test chip select done");
      // Decimal count: one step from d000 must borrow through three decades.
      n = {4'($urandom_range(9, 1)), 12'h000};
      wr(timer_pkg::PORT_CTRL, cw(2'h0, timer_pkg::ACC_BOTH, 3'h0) | 8'h01);
      wr(2'h0, n[7:0]);
      wr(2'h0, n[15:8]);
      tick(3'h1);
      count_gate = 3'h1;
      tick(3'h1);
      count_gate = 3'h0;
      rd16(2'h0, w);
      check("decimal", w, {n[15:12] - 4'h1, 12'h999});
      $display("test decimal done");
      give_verdict();
   end
endmodule

// [bench/interval_timer_checker.sv]
module interval_timer_checker (
   // Clock, reset and enable.
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       ce,
   // Host bus pins.
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic       port_select_lo,
   input wire logic       port_select_hi,
   input wire logic       chip_sel_n,
   input wire logic       read_n,
   input wire logic       write_n,
   // Counter pins.
   input wire logic [2:0] count_clk,
   input wire logic [2:0] count_gate,
   input wire logic [2:0] count_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_reset_quiet: assert property ($rose(rst_n) |-> data_oe_n && count_out == 3'h0)
      else $error("bus or outputs not quiet after reset");
   a_sel_gates_read: assert property (chip_sel_n [*6] |-> data_oe_n)
      else $error("bus driven without chip select");
   a_idle_read_mute: assert property (read_n [*6] |-> data_oe_n)
      else $error("bus driven without read strobe");
   a_ctrl_port_mute: assert property ((port_select_hi && port_select_lo) [*6] |-> data_oe_n)
      else $error("control port drove the bus");
   a_read_answers: assert property ((!read_n && !chip_sel_n && write_n &&
      !(port_select_hi && port_select_lo)) [*4] |-> !data_oe_n)
      else $error("counter read not answered in three cycles");
   a_write_no_drive: assert property ((!write_n && !chip_sel_n) [*4] |-> data_oe_n)
      else $error("bus driven during a write");
   a_oe_release: assert property ($rose(read_n) |-> ##[1:4] data_oe_n)
      else $error("bus not released after read");
   a_bus_zero_idle: assert property (data_oe_n |-> data_out == 8'h00)
      else $error("read data not zero while released");
   a_out_needs_event: assert property ((write_n && count_clk == 3'h7) [*8] |-> $stable(count_out))
      else $error("counter output moved without clock or write");

   c_read: cover property (!read_n && !chip_sel_n ##4 !data_oe_n);
   c_ctrl_write: cover property (!write_n && !chip_sel_n && port_select_hi && port_select_lo);
   c_terminal: cover property ($rose(count_out[1]));
endmodule

bind interval_timer interval_timer_checker chk_u (
   .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .data_in(data_in), .data_out(data_out),
   .data_oe_n(data_oe_n), .port_select_lo(port_select_lo), .port_select_hi(port_select_hi),
   .chip_sel_n(chip_sel_n), .read_n(read_n), .write_n(write_n), .count_clk(count_clk),
   .count_gate(count_gate), .count_out(count_out)
);

// [pkg/timer_pkg.sv]
package timer_pkg;

   // Channel count and bus port map.
   localparam int         N_CHAN       = 3;
   localparam logic [1:0] PORT_CTRL    = 2'h3;

   // Control word field positions.
   localparam int         SEL_POS      = 6;
   localparam int         ACC_POS      = 4;
   localparam int         MODE_POS     = 1;
   localparam int         BCD_POS      = 0;
   localparam int         CTRL_W       = 6;

   // Read-back command bit positions; both latch bits are active low.
   localparam int         RB_CNT_N_POS = 5;
   localparam int         RB_STS_N_POS = 4;
   localparam int         RB_CHAN_POS  = 1;

   // Counter pick and byte access codes.
   localparam logic [1:0] SEL_READBACK = 2'h3;
   localparam logic [1:0] ACC_LATCH    = 2'h0;
   localparam logic [1:0] ACC_LO_ONLY  = 2'h1;
   localparam logic [1:0] ACC_HI_ONLY  = 2'h2;
   localparam logic [1:0] ACC_BOTH     = 2'h3;

   // Mode field bit meanings.
   localparam int         MODE_SQUARE_BIT   = 0;
   localparam int         MODE_PERIODIC_BIT = 1;
   localparam int         MODE_STROBE_BIT   = 2;
   localparam logic [2:0] MODE_TERM_IRQ     = 3'h0;

   // Count constants.
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE  = 16'h0001;
   localparam logic [3:0]  DIGIT_ZERO = 4'h0;
   localparam logic [3:0]  DIGIT_NINE = 4'h9;
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [1:0]  PORT_ZERO  = 2'h0;

   // Pin synchroniser width: data, two selects, chip select, read, write, clocks, gates.
   localparam int         SYNC_W = 8 + 5 + 2 * N_CHAN;

   typedef enum logic [2:0] {
      BUS_IDLE  = 3'h1,
      BUS_WRITE = 3'h2,
      BUS_READ  = 3'h4
   } bus_state_e;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic              programmed;
      logic [7:0]        holding_low_byte;
      logic [7:0]        holding_high_byte;
      logic [15:0]       count;
      logic [15:0]       count_readout_latch;
      logic              latched;
      logic [7:0]        status;
      logic              status_latched;
      logic              wr_high_next;
      logic              rd_high_next;
      logic              load_pend;
      logic              null_count;
      logic              out;
   } chan_s;

endpackage

// [rtl/interval_timer.sv]
// Behaviour
// - Eight-bit three-state data bus carries all traffic.
// - Port select 11 writes the control word.
// - Low read strobe drives selected counter data.
// - Low write strobe takes control word or count.
// - Strobes ignored unless chip select is low.
// - Control word write-only; status via read-back.
// - Status holds control word, output, null count.
// - Three identical counters run independently.
// - Sixteen-bit down counter loaded only from holding.
// - Readout latch tracks count, freezes when latched.
// - Sixteen-bit readout moves one byte per access.
// - Reads return readout latch, never counter.
// - Count bytes go to holding register first.
// - Both holding bytes transfer to counter together.
// - Programming clears both holding bytes.
// - Nothing defined until a counter is programmed.
// - Control word applies to the counter it picks.
// - Per-counter state allows any cross-counter interleave.
// - Control word: pick, access, mode, decimal fields.
// - Access codes: latch, low, high, low-then-high.
// - Decimal bit selects four-decade decimal counting.
module interval_timer (
   // Clock, reset and enable.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Host bus pins.
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe_n,
   input  wire logic        port_select_lo,
   input  wire logic        port_select_hi,
   input  wire logic        chip_sel_n,
   input  wire logic        read_n,
   input  wire logic        write_n,
   // Counter pins.
   input  wire logic [2:0]  count_clk,
   input  wire logic [2:0]  count_gate,
   output logic      [2:0]  count_out
);

   localparam int NC = timer_pkg::N_CHAN;

   typedef struct packed {
      timer_pkg::bus_state_e  bus;
      logic [7:0]             wr_data;
      logic [1:0]             port;
      logic [NC-1:0]          clk_prev;
      timer_pkg::chan_s [NC-1:0] chan;
      logic [7:0]             data_out;
      logic                   data_oe_n;
   } top_s;

   top_s q;
   top_s d;

   logic [timer_pkg::SYNC_W-1:0] pins_s;
   logic [7:0]                   data_s;
   logic [1:0]                   port_s;
   logic                         cs_s;
   logic                         rd_s;
   logic                         wr_s;
   logic [NC-1:0]                clk_s;
   logic [NC-1:0]                gate_s;

   // Strobes enter the synchroniser inverted, so its reset value reads as idle and no false access follows reset.
   pin_sync #(
      .W (timer_pkg::SYNC_W)
   ) u_pin_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in ({data_in, port_select_hi, port_select_lo, ~chip_sel_n, ~read_n, ~write_n, count_clk, count_gate}),
      .sync_out (pins_s)
   );

   assign {data_s, port_s, cs_s, rd_s, wr_s, clk_s, gate_s} = pins_s;

   // Decimal decrement over four decades with borrow; zero wraps to 9999.
   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (borrow) begin
            if (v[4*k +: 4] == timer_pkg::DIGIT_ZERO) begin
               r[4*k +: 4] = timer_pkg::DIGIT_NINE;
            end else begin
               r[4*k +: 4] = v[4*k +: 4] - 4'h1;
               borrow      = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // Byte presented for a read of one channel.
   function automatic logic [7:0] read_byte(input timer_pkg::chan_s c);
      logic [1:0] acc;
      acc = c.ctrl[timer_pkg::ACC_POS +: 2];
      if (c.status_latched) begin
         read_byte = c.status;
      end else if (acc == timer_pkg::ACC_HI_ONLY) begin
         read_byte = c.count_readout_latch[15:8];
      end else if (acc == timer_pkg::ACC_BOTH && c.rd_high_next) begin
         read_byte = c.count_readout_latch[15:8];
      end else begin
         read_byte = c.count_readout_latch[7:0];
      end
   endfunction

   always_comb begin
      logic          wr_act;
      logic          rd_act;
      logic          commit;
      logic [NC-1:0] wr_cnt;
      logic [NC-1:0] prog;
      logic [NC-1:0] latch_cnt;
      logic [NC-1:0] latch_sts;
      logic [NC-1:0] rd_done;
      logic [NC-1:0] tick;
      logic [1:0]    sel;
      logic [1:0]    acc;
      logic [2:0]    mode;
      logic [15:0]   next;
      d         = q;
      wr_act    = wr_s && cs_s;
      rd_act    = rd_s && cs_s;
      commit    = 1'b0;
      wr_cnt    = '0;
      prog      = '0;
      latch_cnt = '0;
      latch_sts = '0;
      rd_done   = '0;
      tick      = q.clk_prev & ~clk_s;
      sel       = q.wr_data[timer_pkg::SEL_POS +: 2];
      acc       = q.wr_data[timer_pkg::ACC_POS +: 2];
      mode      = 3'h0;
      next      = timer_pkg::COUNT_ZERO;

      d.clk_prev = clk_s;

      // Host access sequencing; a write takes effect when its strobe rises.
      case (q.bus)
         timer_pkg::BUS_IDLE: begin
            d.port    = port_s;
            d.wr_data = data_s;
            if (wr_act) begin
               d.bus = timer_pkg::BUS_WRITE;
            end else if (rd_act) begin
               d.bus = timer_pkg::BUS_READ;
            end
         end
         timer_pkg::BUS_WRITE: begin
            if (wr_act) begin
               d.wr_data = data_s;
               d.port    = port_s;
            end else begin
               commit = 1'b1;
               d.bus  = timer_pkg::BUS_IDLE;
            end
         end
         timer_pkg::BUS_READ: begin
            if (!rd_act) begin
               if (q.port != timer_pkg::PORT_CTRL) begin
                  rd_done[q.port] = 1'b1;
               end
               d.bus = timer_pkg::BUS_IDLE;
            end
         end
         default: begin
            d.bus = timer_pkg::BUS_IDLE;
         end
      endcase

      // Decode a committed write into per-channel events.
      if (commit) begin
         if (q.port == timer_pkg::PORT_CTRL) begin
            if (sel == timer_pkg::SEL_READBACK) begin
               for (int i = 0; i < NC; i++) begin
                  if (q.wr_data[timer_pkg::RB_CHAN_POS + i]) begin
                     latch_cnt[i] = !q.wr_data[timer_pkg::RB_CNT_N_POS];
                     latch_sts[i] = !q.wr_data[timer_pkg::RB_STS_N_POS];
                  end
               end
            end else if (acc == timer_pkg::ACC_LATCH) begin
               latch_cnt[sel] = 1'b1;
            end else begin
               prog[sel] = 1'b1;
            end
         end else begin
            wr_cnt[q.port] = 1'b1;
         end
      end

      // Each channel keeps its own programming and readout state.
      for (int i = 0; i < NC; i++) begin
         acc  = q.chan[i].ctrl[timer_pkg::ACC_POS +: 2];
         mode = q.chan[i].ctrl[timer_pkg::MODE_POS +: 3];

         // Readout latch follows the counter unless frozen.
         if (!q.chan[i].latched) begin
            d.chan[i].count_readout_latch = q.chan[i].count;
         end

         // Counting on each falling edge of the channel clock while gated on.
         if (tick[i] && q.chan[i].programmed) begin
            if (q.chan[i].load_pend) begin
               d.chan[i].count      = {q.chan[i].holding_high_byte, q.chan[i].holding_low_byte};
               d.chan[i].load_pend  = 1'b0;
               d.chan[i].null_count = 1'b0;
            end else if (gate_s[i]) begin
               if (q.chan[i].ctrl[timer_pkg::BCD_POS]) begin
                  next = bcd_dec(q.chan[i].count);
               end else begin
                  next = q.chan[i].count - timer_pkg::COUNT_ONE;
               end
               if (q.chan[i].count == timer_pkg::COUNT_ONE) begin
                  if (mode[timer_pkg::MODE_PERIODIC_BIT]) begin
                     // Periodic modes reload both bytes at once at terminal count.
                     d.chan[i].count = {q.chan[i].holding_high_byte, q.chan[i].holding_low_byte};
                     d.chan[i].out   = mode[timer_pkg::MODE_SQUARE_BIT] ? !q.chan[i].out : 1'b0;
                  end else begin
                     d.chan[i].count = next;
                     d.chan[i].out   = !mode[timer_pkg::MODE_STROBE_BIT];
                  end
               end else begin
                  d.chan[i].count = next;
                  if (!q.chan[i].out && mode != timer_pkg::MODE_TERM_IRQ && !mode[timer_pkg::MODE_SQUARE_BIT]) begin
                     d.chan[i].out = 1'b1;
                  end
               end
            end
         end

         // Count bytes land in the holding register in the programmed format.
         if (wr_cnt[i] && q.chan[i].programmed) begin
            case (acc)
               timer_pkg::ACC_LO_ONLY: begin
                  d.chan[i].holding_low_byte = q.wr_data;
                  d.chan[i].load_pend        = 1'b1;
                  d.chan[i].null_count       = 1'b1;
               end
               timer_pkg::ACC_HI_ONLY: begin
                  d.chan[i].holding_high_byte = q.wr_data;
                  d.chan[i].load_pend         = 1'b1;
                  d.chan[i].null_count        = 1'b1;
               end
               timer_pkg::ACC_BOTH: begin
                  if (q.chan[i].wr_high_next) begin
                     d.chan[i].holding_high_byte = q.wr_data;
                     d.chan[i].wr_high_next      = 1'b0;
                     d.chan[i].load_pend         = 1'b1;
                     d.chan[i].null_count        = 1'b1;
                  end else begin
                     d.chan[i].holding_low_byte = q.wr_data;
                     d.chan[i].wr_high_next     = 1'b1;
                  end
               end
               default: begin
                  d.chan[i].load_pend = q.chan[i].load_pend;
               end
            endcase
         end

         // A finished read advances the byte pointer and releases latches.
         if (rd_done[i]) begin
            if (q.chan[i].status_latched) begin
               d.chan[i].status_latched = 1'b0;
            end else if (acc == timer_pkg::ACC_BOTH && !q.chan[i].rd_high_next) begin
               d.chan[i].rd_high_next = 1'b1;
            end else begin
               d.chan[i].rd_high_next = 1'b0;
               d.chan[i].latched      = 1'b0;
            end
         end

         // A second latch before the read is ignored.
         if (latch_cnt[i] && !q.chan[i].latched) begin
            d.chan[i].latched             = 1'b1;
            d.chan[i].count_readout_latch = q.chan[i].count;
         end
         if (latch_sts[i] && !q.chan[i].status_latched) begin
            d.chan[i].status_latched = 1'b1;
            d.chan[i].status         = {q.chan[i].out, q.chan[i].null_count, q.chan[i].ctrl};
         end

         // Programming wins over everything else in the same cycle.
         if (prog[i]) begin
            d.chan[i].ctrl              = q.wr_data[timer_pkg::CTRL_W-1:0];
            d.chan[i].programmed        = 1'b1;
            d.chan[i].holding_low_byte  = timer_pkg::BYTE_ZERO;
            d.chan[i].holding_high_byte = timer_pkg::BYTE_ZERO;
            d.chan[i].wr_high_next      = 1'b0;
            d.chan[i].rd_high_next      = 1'b0;
            d.chan[i].latched           = 1'b0;
            d.chan[i].status_latched    = 1'b0;
            d.chan[i].load_pend         = 1'b0;
            d.chan[i].null_count        = 1'b1;
            d.chan[i].out               = q.wr_data[timer_pkg::MODE_POS +: 3] != timer_pkg::MODE_TERM_IRQ;
         end
      end

      // The control port is write-only, so a read there leaves the bus undriven.
      if (rd_act && port_s != timer_pkg::PORT_CTRL) begin
         d.data_out  = read_byte(q.chan[port_s]);
         d.data_oe_n = 1'b0;
      end else begin
         d.data_out  = timer_pkg::BYTE_ZERO;
         d.data_oe_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q           <= '0;
         q.bus       <= timer_pkg::BUS_IDLE;
         q.data_oe_n <= 1'b1;
      end else if (ce) begin
         q <= d;
      end
   end

   assign data_out  = q.data_out;
   assign data_oe_n = q.data_oe_n;

   generate
      for (genvar g = 0; g < NC; g++) begin : g_out
         assign count_out[g] = q.chan[g].out;
      end
   endgenerate

endmodule

// [rtl/pin_sync.sv]
module pin_sync #(
   parameter int W = 1
) (
   // Clock, reset and enable.
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Pins and their synchronised copy.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;

   sync_s q;
   sync_s d;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_comb begin
      d    = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule
